// File: rtl/fmrx_pkg.sv
// Shared constants for the FM receiver control link
package fmrx_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h10;
	localparam logic [7:0] ADDR_WR = 8'h20;
	localparam logic [7:0] ADDR_RD = 8'h21;
	localparam int REG_COUNT = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_AUDIO = 8'h14;
	localparam logic [7:0] REG_RSSI = 8'h05;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam int BIT_MONO = 2;
	localparam int BIT_MUTE = 7;
	localparam int BIT_TONE = 6;
	localparam int BIT_DEEMPH = 0;
	localparam int BIT_INJECT = 1;
	localparam int BIT_SEEK = 2;
	localparam int BIT_STEREO = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] AUDIO_RST = 8'h00;
	localparam int CLK_HZ = 20000000;
	localparam int BUS_HZ = 400000;
	// Quarter bit period, rounded up so the bus never runs too fast
	localparam int QTR_CYC = (CLK_HZ / BUS_HZ + 3) / 4;
	localparam logic [7:0] RSSI_GOOD = 8'h28;
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_SUB = 8'h04;
	localparam logic [7:0] APB_WDAT = 8'h08;
	localparam logic [7:0] APB_STAT = 8'h0C;
	localparam logic [7:0] APB_RDAT = 8'h10;
endpackage

// File: rtl/fmrx_link_if.sv
// Two-wire bus between host master and receiver slave
`timescale 1ns/1ps
interface fmrx_link_if;
	logic sclOut, sclOe;
	logic sdaMstOut, sdaMstOe;
	logic sdaSlvOut, sdaSlvOe;
	logic scl, sda;
	// Open drain with pull-up
	assign scl = !(sclOe && !sclOut);
	assign sda = !((sdaMstOe && !sdaMstOut) || (sdaSlvOe && !sdaSlvOut));
	modport master (output sclOut, sclOe, sdaMstOut, sdaMstOe,
		input scl, sda);
	modport slave (output sdaSlvOut, sdaSlvOe, input scl, sda);
endinterface

// File: rtl/fmrx_slave.sv
// Receiver side: two-wire slave, register file and audio controls
`timescale 1ns/1ps
module fmrx_slave (
	input wire logic mclk,
	input wire logic arst_n,
	fmrx_link_if.slave link,
	input wire logic [7:0] signalStrength,
	input wire logic stereoDetect,
	input wire logic rfPresent,
	output logic monoOut,
	output logic muteOut,
	output logic toneOut,
	output logic deemph75Out,
	output logic highInjectOut,
	output logic seekTuneOut
);
	import fmrx_pkg::*;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ADDR = 5'b00010,
		S_RX = 5'b00100,
		S_TX = 5'b01000,
		S_ACK = 5'b10000
	} fmrx_sst_t;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sclSy_q, sclSy_d, sdaSy_q, sdaSy_d;
	logic sclF_q, sclF_d, sdaF_q, sdaF_d;
	always_comb begin
		sclSy_d = {sclSy_q[1:0], link.scl};
		sdaSy_d = {sdaSy_q[1:0], link.sda};
		sclF_d = (sclSy_q[1] == sclSy_q[2]) ? sclSy_q[2] : sclF_q;
		sdaF_d = (sdaSy_q[1] == sdaSy_q[2]) ? sdaSy_q[2] : sdaF_q;
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sclSy_q <= 3'h7;
			sdaSy_q <= 3'h7;
			sclF_q <= 1'b1;
			sdaF_q <= 1'b1;
		end else begin
			sclSy_q <= sclSy_d;
			sdaSy_q <= sdaSy_d;
			sclF_q <= sclF_d;
			sdaF_q <= sdaF_d;
		end
	end
	wire sclRise = sclF_d && !sclF_q;
	wire sclFall = !sclF_d && sclF_q;
	wire startEv = sclF_q && sclF_d && sdaF_q && !sdaF_d;
	wire stopEv = sclF_q && sclF_d && !sdaF_q && sdaF_d;

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	fmrx_sst_t st_q, st_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shf_q, shf_d;
	logic [7:0] ptr_q, ptr_d;
	logic isRead_q, isRead_d, subDone_q, subDone_d;
	logic ackDrv_q, ackDrv_d, sdaLow_q, sdaLow_d;
	logic wrEn;
	logic [7:0] regFile_q [REG_COUNT];
	logic [7:0] regFile_d [REG_COUNT];
	logic [7:0] rdData;

	always_comb begin
		rdData = 8'h00;
		if (ptr_q == REG_STAT)
			rdData = {7'h00, stereoDetect && !monoOut};
		else if (ptr_q == REG_RSSI)
			rdData = signalStrength;
		else if (ptr_q < 8'(REG_COUNT))
			rdData = regFile_q[ptr_q[4:0]];
	end

	always_comb begin
		st_d = st_q;
		bitCnt_d = bitCnt_q;
		shf_d = shf_q;
		ptr_d = ptr_q;
		isRead_d = isRead_q;
		subDone_d = subDone_q;
		ackDrv_d = ackDrv_q;
		sdaLow_d = sdaLow_q;
		wrEn = 1'b0;
		if (startEv) begin
			st_d = S_ADDR;
			bitCnt_d = 4'h0;
			subDone_d = 1'b0;
			sdaLow_d = 1'b0;
		end else if (stopEv) begin
			st_d = S_IDLE;
			sdaLow_d = 1'b0;
		end else begin
			unique case (st_q)
			S_IDLE: ;
			S_ADDR, S_RX: begin
				if (sclRise) begin
					shf_d = {shf_q[6:0], sdaF_q};
					bitCnt_d = bitCnt_q + 4'h1;
				end
				if (sclFall && bitCnt_q == 4'h8) begin
					ackDrv_d = 1'b1;
					if (st_q == S_ADDR) begin
						if (shf_q[7:1] == SLAVE_ADDR) begin
							isRead_d = shf_q[0];
							sdaLow_d = 1'b1;
							st_d = S_ACK;
						end else begin
							st_d = S_IDLE;
						end
					end else begin
						sdaLow_d = 1'b1;
						st_d = S_ACK;
						if (!subDone_q) begin
							ptr_d = shf_q;
							subDone_d = 1'b1;
						end else begin
							wrEn = 1'b1;
							ptr_d = ptr_q + 8'h01;
						end
					end
				end
			end
			S_ACK: begin
				// Ack bit of a read byte is the master's answer
				if (sclRise && !ackDrv_q && sdaF_q) begin
					st_d = S_IDLE;
				end
				if (sclFall) begin
					bitCnt_d = 4'h0;
					if (isRead_q) begin
						shf_d = {rdData[6:0], 1'b0};
						sdaLow_d = !rdData[7];
						st_d = S_TX;
					end else begin
						sdaLow_d = 1'b0;
						st_d = S_RX;
					end
				end
			end
			S_TX: begin
				if (sclFall) begin
					bitCnt_d = bitCnt_q + 4'h1;
					if (bitCnt_q == 4'h7) begin
						sdaLow_d = 1'b0;
						ackDrv_d = 1'b0;
						ptr_d = ptr_q + 8'h01;
						st_d = S_ACK;
					end else begin
						sdaLow_d = !shf_q[7];
						shf_d = {shf_q[6:0], 1'b0};
					end
				end
			end
			default: st_d = S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : gRegs
			always_comb begin
				regFile_d[gi] = regFile_q[gi];
				if (wrEn && ptr_q == 8'(gi))
					regFile_d[gi] = shf_q;
			end
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n)
					regFile_q[gi] <= 8'h00;
				else
					regFile_q[gi] <= regFile_d[gi];
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= S_IDLE;
			bitCnt_q <= 4'h0;
			shf_q <= 8'h00;
			ptr_q <= 8'h00;
			isRead_q <= 1'b0;
			subDone_q <= 1'b0;
			ackDrv_q <= 1'b0;
			sdaLow_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bitCnt_q <= bitCnt_d;
			shf_q <= shf_d;
			ptr_q <= ptr_d;
			isRead_q <= isRead_d;
			subDone_q <= subDone_d;
			ackDrv_q <= ackDrv_d;
			sdaLow_q <= sdaLow_d;
		end
	end
	assign link.sdaSlvOut = 1'b0;
	assign link.sdaSlvOe = sdaLow_q;

	// ----------------------------------------
	// Audio and tuner controls
	// ----------------------------------------
	logic [5:0] ctl_q, ctl_d;
	always_comb begin
		ctl_d[0] = regFile_q[REG_CTRL[4:0]][BIT_MONO];
		ctl_d[1] = regFile_q[REG_AUDIO[4:0]][BIT_MUTE];
		ctl_d[2] = regFile_q[REG_AUDIO[4:0]][BIT_TONE] && rfPresent;
		ctl_d[3] = !regFile_q[REG_CFG[4:0]][BIT_DEEMPH];
		ctl_d[4] = regFile_q[REG_CFG[4:0]][BIT_INJECT];
		// Seek holds only on a channel with enough strength
		ctl_d[5] = regFile_q[REG_CFG[4:0]][BIT_SEEK]
			&& signalStrength >= RSSI_GOOD;
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ctl_q <= 6'h00;
		else
			ctl_q <= ctl_d;
	end
	assign monoOut = ctl_q[0];
	assign muteOut = ctl_q[1];
	assign toneOut = ctl_q[2];
	assign deemph75Out = ctl_q[3];
	assign highInjectOut = ctl_q[4];
	assign seekTuneOut = ctl_q[5];
endmodule

// File: rtl/fmrx_master.sv
// Host side: APB-controlled two-wire master for the receiver
`timescale 1ns/1ps
module fmrx_master (
	input wire logic mclk,
	input wire logic arst_n,
	fmrx_link_if.master link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import fmrx_pkg::*;

	typedef enum logic [6:0] {
		M_IDLE = 7'b0000001,
		M_START = 7'b0000010,
		M_BIT = 7'b0000100,
		M_STOP = 7'b0001000,
		M_DONE = 7'b0010000,
		M_RESTART = 7'b0100000,
		M_GAP = 7'b1000000
	} fmrx_mst_t;

	// ----------------------------------------
	// APB registers
	// ----------------------------------------
	// CMD: bit0 go, bit1 read; SUB sub-address; WDAT data byte
	logic [7:0] sub_q, sub_d, wdat_q, wdat_d, rdat_q, rdat_d;
	logic rd_q, rd_d, busy_q, busy_d, nack_q, nack_d;
	logic [31:0] prdata_d;
	logic pready_d;
	wire apbWr = psel && penable && pwrite && pready;
	wire apbRd = psel && !penable && !pwrite;
	wire goCmd = apbWr && paddr == APB_CMD && pwdata[0] && !busy_q;

	always_comb begin
		prdata_d = prdata;
		if (apbRd) begin
			unique case (paddr)
			APB_SUB: prdata_d = {24'h0, sub_q};
			APB_WDAT: prdata_d = {24'h0, wdat_q};
			APB_STAT: prdata_d = {30'h0, nack_q, busy_q};
			APB_RDAT: prdata_d = {24'h0, rdat_q};
			default: prdata_d = 32'h0;
			endcase
		end
		pready_d = psel && !penable;
	end

	// ----------------------------------------
	// Bus engine
	// ----------------------------------------
	fmrx_mst_t st_q, st_d;
	logic [7:0] div_q, div_d;
	logic [1:0] ph_q, ph_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] byt_q, byt_d;
	logic [1:0] pass_q, pass_d;
	logic [8:0] sh_q, sh_d;
	logic sclO_q, sclO_d, sdaO_q, sdaO_d;
	wire tick = div_q == 8'(QTR_CYC - 1);

	// Byte currently sent: address, sub-address, data
	// A received byte is always the last one, so its ack slot stays high
	function automatic logic [8:0] frame(input logic [7:0] b, input logic rx);
		frame = rx ? 9'h1FF : {b, 1'b1};
	endfunction

	always_comb begin
		st_d = st_q;
		div_d = tick ? 8'h00 : div_q + 8'h01;
		ph_d = ph_q;
		bit_d = bit_q;
		byt_d = byt_q;
		pass_d = pass_q;
		sh_d = sh_q;
		sclO_d = sclO_q;
		sdaO_d = sdaO_q;
		sub_d = (apbWr && paddr == APB_SUB) ? pwdata[7:0] : sub_q;
		wdat_d = (apbWr && paddr == APB_WDAT) ? pwdata[7:0] : wdat_q;
		rd_d = goCmd ? pwdata[1] : rd_q;
		busy_d = busy_q || goCmd;
		nack_d = goCmd ? 1'b0 : nack_q;
		rdat_d = rdat_q;
		unique case (st_q)
		M_IDLE: if (busy_q && tick) begin
			st_d = M_START;
			pass_d = 2'h0;
			ph_d = 2'h0;
		end
		M_START: if (tick) begin
			ph_d = ph_q + 2'h1;
			if (ph_q == 2'h0) sdaO_d = 1'b0;
			if (ph_q == 2'h1) begin
				sclO_d = 1'b0;
				byt_d = 2'h0;
				bit_d = 4'h0;
				// Second pass of a read opens with direction 1
				sh_d = {(pass_q == 2'h1) ? ADDR_RD : ADDR_WR, 1'b1};
				st_d = M_BIT;
				ph_d = 2'h0;
			end
		end
		M_BIT: if (tick) begin
			ph_d = ph_q + 2'h1;
			unique case (ph_q)
			2'h0: sdaO_d = sh_q[8];
			2'h1: sclO_d = 1'b1;
			2'h2: if (link.scl) begin
				sh_d = {sh_q[7:0], link.sda};
			end else begin
				ph_d = ph_q; // clock stretched
			end
			2'h3: begin
				sclO_d = 1'b0;
				bit_d = bit_q + 4'h1;
				if (bit_q == 4'h8) begin
					bit_d = 4'h0;
					byt_d = byt_q + 2'h1;
					if (pass_q == 2'h1 && byt_q != 2'h0) begin
						rdat_d = sh_q[8:1];
						st_d = M_STOP;
					end else if (sh_q[0]) begin
						nack_d = 1'b1;
						st_d = M_STOP;
					end else if (pass_q == 2'h1) begin
						sh_d = frame(8'h00, 1'b1);
					end else if (byt_q == 2'h0) begin
						sh_d = {sub_q, 1'b1};
					end else if (byt_q == 2'h1 && !rd_q) begin
						sh_d = {wdat_q, 1'b1};
					end else begin
						st_d = M_STOP;
					end
				end
			end
			endcase
		end
		M_STOP: if (tick) begin
			ph_d = ph_q + 2'h1;
			if (ph_q == 2'h0) sdaO_d = 1'b0;
			if (ph_q == 2'h1) sclO_d = 1'b1;
			if (ph_q == 2'h2) sdaO_d = 1'b1;
			if (ph_q == 2'h3)
				st_d = (rd_q && pass_q == 2'h0 && !nack_q) ? M_GAP : M_DONE;
		end
		M_GAP: if (tick) begin
			st_d = M_RESTART;
		end
		M_RESTART: begin
			pass_d = 2'h1;
			ph_d = 2'h0;
			st_d = M_START;
		end
		M_DONE: begin
			busy_d = 1'b0;
			st_d = M_IDLE;
		end
		default: st_d = M_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= M_IDLE;
			div_q <= 8'h00;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			byt_q <= 2'h0;
			pass_q <= 2'h0;
			sh_q <= 9'h1FF;
			sclO_q <= 1'b1;
			sdaO_q <= 1'b1;
			sub_q <= 8'h00;
			wdat_q <= 8'h00;
			rdat_q <= 8'h00;
			rd_q <= 1'b0;
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			byt_q <= byt_d;
			pass_q <= pass_d;
			sh_q <= sh_d;
			sclO_q <= sclO_d;
			sdaO_q <= sdaO_d;
			sub_q <= sub_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			rd_q <= rd_d;
			busy_q <= busy_d;
			nack_q <= nack_d;
			prdata <= prdata_d;
			pready <= pready_d;
		end
	end
	assign pslverr = 1'b0;
	assign link.sclOut = 1'b0;
	assign link.sclOe = !sclO_q;
	assign link.sdaMstOut = 1'b0;
	assign link.sdaMstOe = !sdaO_q;
endmodule

// File: dv/fmrx_link_assertions.sv
// Checker watching the two-wire link between both ends
`timescale 1ns/1ps
module fmrx_link_assertions
	import fmrx_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sclOe,
	input wire logic sdaMstOe,
	input wire logic sdaSlvOe
);
	localparam int MinPer = CLK_HZ / BUS_HZ;
	logic sclPrev_q, sdaPrev_q, rdDir_q;
	logic [3:0] bitCnt_q, byteCnt_q;
	logic [7:0] shift_q;
	logic [6:0] period_q;
	wire sclRise = scl && !sclPrev_q;
	wire startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
	wire stopSeen = scl && sclPrev_q && !sdaPrev_q && sda;

	// -----------------------------------------------
	// Bit and byte tracking
	// -----------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
			rdDir_q <= 1'b0;
			bitCnt_q <= 4'h0;
			byteCnt_q <= 4'h0;
			shift_q <= 8'h00;
			period_q <= 7'h7F;
		end else begin
			sclPrev_q <= scl;
			sdaPrev_q <= sda;
			// Saturates so idle gaps never wrap into a short period
			period_q <= sclRise ? 7'h01 : period_q + {6'h00, period_q != 7'h7F};
			if (startSeen) begin
				bitCnt_q <= 4'h0;
				byteCnt_q <= 4'h0;
			end else if (sclRise) begin
				shift_q <= {shift_q[6:0], sda};
				bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
				if (bitCnt_q == 4'h8)
					byteCnt_q <= byteCnt_q + {3'h0, byteCnt_q != 4'hF};
				if (bitCnt_q == 4'h7 && byteCnt_q == 4'h0)
					rdDir_q <= sda;
			end
		end
	end

	// -----------------------------------------------
	// Properties
	// -----------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence s_ackSlot;
		sclRise && bitCnt_q == 4'h8;
	endsequence

	a_scl_period: assert property (sclRise |-> period_q >= 7'(MinPer))
		else $error("clock period shorter than allowed");
	a_scl_low: assert property ($fell(scl) |=> !scl [*8])
		else $error("clock low phase too short");
	a_slave_stable: assert property (scl && sclPrev_q |-> $stable(sdaSlvOe))
		else $error("slave moved data while clock high");
	a_master_stable: assert property (scl && sclPrev_q &&
		$changed(sdaMstOe) |-> startSeen || stopSeen)
		else $error("master moved data while clock high");
	a_start_free: assert property (startSeen |-> !sdaSlvOe)
		else $error("slave drives data at start");
	a_addr_ack: assert property (s_ackSlot ##0
		(byteCnt_q == 4'h0 && shift_q[7:1] == SLAVE_ADDR) |-> !sda)
		else $error("own address not acknowledged");
	a_write_ack: assert property (s_ackSlot ##0
		(byteCnt_q != 4'h0 && !rdDir_q) |-> !sda)
		else $error("written byte not acknowledged");
	a_nack_release: assert property (s_ackSlot ##0
		(byteCnt_q != 4'h0 && rdDir_q && sda) |-> !sdaSlvOe [*8])
		else $error("slave holds data after not-acknowledge");
	a_reset_idle: assert property ($rose(arst_n) |->
		!sdaSlvOe && !sdaMstOe && !sclOe)
		else $error("lines not released after reset");
endmodule

// File: dv/fm_receiver_i2c_control_tb_top.sv
// Bench: APB-driven master against the receiver slave
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin \
	errorCnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module fm_receiver_i2c_control_tb_top;
	import fmrx_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr;
	logic [7:0] signalStrength = 8'h00;
	logic stereoDetect = 1'b0, rfPresent = 1'b0;
	logic monoOut, muteOut, toneOut, deemph75Out, highInjectOut, seekTuneOut;
	wire [5:0] outs = {monoOut, muteOut, toneOut, deemph75Out, highInjectOut,
		seekTuneOut};
	int errorCnt = 0, cmpCount = 0;

	always #25 mclk = ~mclk;

	fmrx_link_if link ();
	fmrx_master u_fmrx_master (.mclk(mclk), .arst_n(arst_n), .link(link),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	fmrx_slave u_fmrx_slave (.mclk(mclk), .arst_n(arst_n), .link(link),
		.signalStrength(signalStrength), .stereoDetect(stereoDetect),
		.rfPresent(rfPresent), .monoOut(monoOut), .muteOut(muteOut),
		.toneOut(toneOut), .deemph75Out(deemph75Out),
		.highInjectOut(highInjectOut), .seekTuneOut(seekTuneOut));
	fmrx_link_assertions u_fmrx_link_assertions (.mclk(mclk),
		.arst_n(arst_n), .scl(link.scl), .sda(link.sda), .sclOe(link.sclOe),
		.sdaMstOe(link.sdaMstOe), .sdaSlvOe(link.sdaSlvOe));

	// ---------------------------------------------
	// Access tasks
	// ---------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-byte link transfer; read data lands in rd
	task automatic xfer(input logic rdOp, input logic [7:0] sub,
		input logic [7:0] d);
		apb(1'b1, APB_SUB, {24'h0, sub});
		apb(1'b1, APB_WDAT, {24'h0, d});
		apb(1'b1, APB_CMD, {30'h0, rdOp, 1'b1});
		do apb(1'b0, APB_STAT, 32'h0);
		while (rd[0] !== 1'b0);
		`CHK("nack", 1'b0, rd[1])
		if (rdOp)
			apb(1'b0, APB_RDAT, 32'h0);
	endtask

	task automatic expRd(input logic [7:0] sub, input logic [7:0] e);
		xfer(1'b1, sub, 8'h00);
		`CHK("regdata", e, rd[7:0])
	endtask

	// Outputs are registered, so let a few edges pass
	task automatic expOut(input logic [5:0] e);
		repeat (3) @(posedge mclk);
		`CHK("outs", e, outs)
	endtask

	task automatic summarize();
		$display("errors %0d compares %0d", errorCnt, cmpCount);
		if (errorCnt == 0 && cmpCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ---------------------------------------------
	// Tests
	// ---------------------------------------------
	initial begin
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		expOut(6'h04);
		expRd(REG_CTRL, CTRL_RST);
		xfer(1'b0, REG_CTRL, 8'h04);
		expOut(6'h24);
		expRd(REG_CTRL, 8'h04);
		xfer(1'b0, REG_CTRL, 8'h00);
		xfer(1'b0, REG_AUDIO, 8'h80);
		expOut(6'h14);
		xfer(1'b0, REG_AUDIO, 8'h40);
		expOut(6'h04);
		rfPresent <= 1'b1;
		expOut(6'h0C);
		xfer(1'b0, REG_AUDIO, 8'h00);
		xfer(1'b0, REG_CFG, 8'h03);
		expOut(6'h02);
		stereoDetect <= 1'b1;
		expRd(REG_STAT, 8'h01);
		// Status is read-only: a write must not stick
		xfer(1'b0, REG_STAT, 8'hFE);
		stereoDetect <= 1'b0;
		expRd(REG_STAT, 8'h00);
		signalStrength <= 8'hA5;
		expRd(REG_RSSI, 8'hA5);
		// Seek holds from the strength threshold upwards
		xfer(1'b0, REG_CFG, 8'h04);
		expOut(6'h05);
		signalStrength <= RSSI_GOOD - 8'h01;
		expOut(6'h04);
		signalStrength <= RSSI_GOOD;
		expOut(6'h05);
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		`CHK("pslverr", 1'b0, pslverr)
		arst_n <= 1'b0;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		expOut(6'h04);
		expRd(REG_CFG, CFG_RST);
		summarize();
	end

	initial begin
		repeat (80000) @(posedge mclk);
		errorCnt++;
		summarize();
	end
endmodule
